// file: design/fsp_defs.svh
// Offsets, field positions, word masks and load constants of the segment protection block
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define FSP_REG_SEC          8'h00
`define FSP_REG_LIM          8'h04
`define FSP_REG_STATUS       8'h08

// ----------------------------------------------------------------
// Security word fields
// ----------------------------------------------------------------
`define FSP_ALT_VEC_DIS_BIT  15
`define FSP_CFG_LVL_HI       11
`define FSP_CFG_LVL_LO       9
`define FSP_CFG_WP_BIT       8
`define FSP_GEN_LVL_HI       7
`define FSP_GEN_LVL_LO       6
`define FSP_GEN_WP_BIT       5
`define FSP_BOOT_CTL_BIT     3
`define FSP_BOOT_LVL_HI      2
`define FSP_BOOT_LVL_LO      1
`define FSP_BOOT_WP_BIT      0

// ----------------------------------------------------------------
// Boot limit word fields
// ----------------------------------------------------------------
`define FSP_PG_LIM_HI        12
`define FSP_PG_LIM_LO        0

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define FSP_ST_VALID_BIT     0
`define FSP_ST_REFUSED_BIT   1
`define FSP_ST_BOOTSEG_BIT   2

// ----------------------------------------------------------------
// Word values
// ----------------------------------------------------------------
`define FSP_UNPROG_WORD      24'hffffff
`define FSP_SEC_IMPL_MASK    24'h008fef
`define FSP_LIM_IMPL_MASK    24'h001fff
`define FSP_SEC_NVM_ADDR     24'h00af00
`define FSP_LIM_NVM_ADDR     24'h00af10

`endif

// file: design/fsp_pkg.sv
// Types and field decoders of the segment protection block
package fsp_pkg;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      LVL_NONE,
      LVL_STANDARD,
      LVL_ENHANCED,
      LVL_HIGH
   } fsp_level_t;

   typedef enum logic [1:0] {
      SEG_BOOT,
      SEG_GENERAL,
      SEG_CONFIG
   } fsp_seg_t;

   typedef enum logic [2:0] {
      ST_RD_SEC,
      ST_WAIT_SEC,
      ST_RD_LIM,
      ST_WAIT_LIM,
      ST_READY
   } fsp_load_t;

   // ----------------------------------------------------------------
   // Decoders
   // ----------------------------------------------------------------
   function automatic fsp_level_t fsp_decode_level3(input logic [2:0] f);
      fsp_level_t l;
      if (f == 3'h7) begin
         l = LVL_NONE;
      end else if (f == 3'h6) begin
         l = LVL_STANDARD;
      end else if (f[2]) begin
         l = LVL_ENHANCED;
      end else begin
         l = LVL_HIGH;
      end
      return l;
   endfunction

   function automatic fsp_level_t fsp_decode_level2(input logic [1:0] f);
      fsp_level_t l;
      if (f == 2'h3) begin
         l = LVL_NONE;
      end else if (f == 2'h2) begin
         l = LVL_STANDARD;
      end else begin
         l = LVL_HIGH;
      end
      return l;
   endfunction

endpackage

// file: design/fsp_word_shadow.sv
// Holding register for one captured configuration word
`timescale 1ns/1ns
`include "fsp_defs.svh"
module fsp_word_shadow #(
   parameter logic [23:0] IMPL_MASK = `FSP_UNPROG_WORD
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // Capture
   input  wire logic        load,
   input  wire logic [23:0] load_data,
   // Held word
   output logic      [23:0] word
);
   import fsp_pkg::*;

   typedef struct packed {
      logic [23:0] word;
   } fsp_shadow_t;

   fsp_shadow_t q;
   fsp_shadow_t next_q;

   always_comb begin
      next_q = q;
      if (load) begin
         next_q.word = load_data | ~IMPL_MASK;
      end
   end

   // Unprogrammed value until the capture: no protection assumed
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         q.word <= `FSP_UNPROG_WORD;
      end else begin
         q <= next_q;
      end
   end

   assign word = q.word;
endmodule

// file: design/fsp_access_check.sv
// Segment classification and write permission for one flash page
`timescale 1ns/1ns
`include "fsp_defs.svh"
module fsp_access_check (
   // Decoded protection
   input  wire logic              boot_present,
   input  wire logic [12:0]       boot_first_general_page,
   input  wire logic              config_wr_locked,
   input  wire logic              general_wr_locked,
   input  wire logic              boot_wr_locked,
   // Access
   input  wire logic              is_config_seg,
   input  wire logic [12:0]       page,
   // Verdict
   output fsp_pkg::fsp_seg_t      segment,
   output logic                   wr_allow
);
   import fsp_pkg::*;

   always_comb begin
      if (is_config_seg) begin
         segment = SEG_CONFIG;
      end else if (boot_present && (page < boot_first_general_page)) begin
         segment = SEG_BOOT;
      end else begin
         segment = SEG_GENERAL;
      end
      unique case (segment)
         SEG_CONFIG:  wr_allow = !config_wr_locked;
         SEG_BOOT:    wr_allow = !boot_wr_locked;
         SEG_GENERAL: wr_allow = !general_wr_locked;
         default:     wr_allow = 1'b0;
      endcase
   end
endmodule

// file: design/fsp_protect_top.sv
// Code protection configuration decoder with program-once register port
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns
`include "fsp_defs.svh"

// Function
// - Security bit 15 at 1 disables the alternate vector table and at 0 enables it.
// - Configuration level field 11..9 decodes 111 none, 110 standard, 10x enhanced, 0xx high.
// - Config segment writes are blocked while bit 8 is 0 and allowed while it is 1.
// - General level field 7..6 decodes 11 none, 10 standard, 0x high.
// - General segment is write-protected while bit 5 is 0 and writable while it is 1.
// - Bit 3 at 1 means no boot segment; at 0 the boot extent comes from the limit field.
// - Boot level field 2..1 decodes 11 none, 10 standard, 0x high.
// - Boot segment is write-protected while bit 0 is 0 and writable while it is 1.
// - The 13-bit limit field holds the inverted first general page and is inverted before use.
// - Unimplemented word positions, bits 23..16 included, read back as 1.
// - Each protection bit is readable, programmable once, and reads 1 when unprogrammed.
module fsp_protect_top #(
   parameter int          NVM_AW       = 24,
   parameter logic [23:0] SEC_NVM_ADDR = `FSP_SEC_NVM_ADDR,
   parameter logic [23:0] LIM_NVM_ADDR = `FSP_LIM_NVM_ADDR
) (
   // Clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   resetn,
   // Register port
   input  wire logic [7:0]             reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [31:0]            reg_rdata,
   // Configuration memory read
   output logic                        nvm_rd_en,
   output logic      [NVM_AW-1:0]      nvm_rd_addr,
   input  wire logic [23:0]            nvm_rd_data,
   // Configuration memory program
   output logic                        nvm_prog_en,
   output logic      [NVM_AW-1:0]      nvm_prog_addr,
   output logic      [23:0]            nvm_prog_data,
   // Flash write check
   input  wire logic                   flash_wr_req,
   input  wire logic                   flash_wr_cfg_seg,
   input  wire logic [12:0]            flash_wr_page,
   output logic                        flash_wr_grant,
   output logic                        flash_wr_deny,
   output fsp_pkg::fsp_seg_t           flash_wr_segment,
   // Decoded protection
   output logic                        config_valid,
   output logic                        alt_vector_table_disable,
   output fsp_pkg::fsp_level_t         config_segment_security_level,
   output fsp_pkg::fsp_level_t         general_segment_security_level,
   output fsp_pkg::fsp_level_t         boot_segment_security_level,
   output logic                        config_segment_wr_locked,
   output logic                        general_segment_wr_locked,
   output logic                        boot_segment_wr_locked,
   output logic                        boot_segment_present,
   output logic      [12:0]            boot_segment_first_general_page
);
   import fsp_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      fsp_load_t         st;
      logic [31:0]       rdata;
      logic              prog_en;
      logic [NVM_AW-1:0] prog_addr;
      logic [23:0]       prog_data;
      logic              refused;
   } fsp_state_t;

   fsp_state_t q;
   fsp_state_t next_q;

   logic [23:0] sec_word;
   logic [23:0] lim_word;
   logic        sec_load;
   logic        lim_load;
   logic        ready;
   logic        wr_allow;
   logic        set_refused;
   logic        clr_refused;

   // ----------------------------------------------------------------
   // Captured words
   // ----------------------------------------------------------------
   // Each word is read once after reset and then only a reset reloads it,
   // so a program pulse never changes the live controls.
   assign sec_load = (q.st == ST_WAIT_SEC);
   assign lim_load = (q.st == ST_WAIT_LIM);
   assign ready    = (q.st == ST_READY);

   fsp_word_shadow #(
      .IMPL_MASK (`FSP_SEC_IMPL_MASK)
   ) u_sec_word (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .load      (sec_load),
      .load_data (nvm_rd_data),
      .word      (sec_word)
   );

   fsp_word_shadow #(
      .IMPL_MASK (`FSP_LIM_IMPL_MASK)
   ) u_lim_word (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .load      (lim_load),
      .load_data (nvm_rd_data),
      .word      (lim_word)
   );

   // ----------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------
   assign config_valid                   = ready;
   assign alt_vector_table_disable       = sec_word[`FSP_ALT_VEC_DIS_BIT];
   assign config_segment_security_level  =
      fsp_decode_level3(sec_word[`FSP_CFG_LVL_HI:`FSP_CFG_LVL_LO]);
   assign general_segment_security_level =
      fsp_decode_level2(sec_word[`FSP_GEN_LVL_HI:`FSP_GEN_LVL_LO]);
   assign boot_segment_security_level    =
      fsp_decode_level2(sec_word[`FSP_BOOT_LVL_HI:`FSP_BOOT_LVL_LO]);
   assign config_segment_wr_locked       = !sec_word[`FSP_CFG_WP_BIT];
   assign general_segment_wr_locked      = !sec_word[`FSP_GEN_WP_BIT];
   assign boot_segment_wr_locked         = !sec_word[`FSP_BOOT_WP_BIT];
   assign boot_segment_present           = !sec_word[`FSP_BOOT_CTL_BIT];
   assign boot_segment_first_general_page =
      ~lim_word[`FSP_PG_LIM_HI:`FSP_PG_LIM_LO];

   // ----------------------------------------------------------------
   // Flash write check
   // ----------------------------------------------------------------
   fsp_access_check u_access (
      .boot_present            (boot_segment_present),
      .boot_first_general_page (boot_segment_first_general_page),
      .config_wr_locked        (config_segment_wr_locked),
      .general_wr_locked       (general_segment_wr_locked),
      .boot_wr_locked          (boot_segment_wr_locked),
      .is_config_seg           (flash_wr_cfg_seg),
      .page                    (flash_wr_page),
      .segment                 (flash_wr_segment),
      .wr_allow                (wr_allow)
   );

   // Nothing is granted before both words are in: the controls are not yet known
   assign flash_wr_grant = flash_wr_req && ready && wr_allow;
   assign flash_wr_deny  = flash_wr_req && !(ready && wr_allow);

   // ----------------------------------------------------------------
   // Configuration memory ports
   // ----------------------------------------------------------------
   assign nvm_rd_en     = (q.st == ST_RD_SEC) || (q.st == ST_RD_LIM);
   assign nvm_rd_addr   = (q.st == ST_RD_LIM) ? LIM_NVM_ADDR[NVM_AW-1:0]
                                              : SEC_NVM_ADDR[NVM_AW-1:0];
   assign nvm_prog_en   = q.prog_en;
   assign nvm_prog_addr = q.prog_addr;
   assign nvm_prog_data = q.prog_data;
   assign reg_rdata     = q.rdata;

   // ----------------------------------------------------------------
   // Refused flag handling
   // ----------------------------------------------------------------
   // Both words live in the config segment, so its write lock guards them
   always_comb begin
      set_refused = 1'b0;
      clr_refused = 1'b0;
      if (reg_wr) begin
         if ((reg_addr == `FSP_REG_SEC) || (reg_addr == `FSP_REG_LIM)) begin
            set_refused = !ready || config_segment_wr_locked;
         end else if (reg_addr == `FSP_REG_STATUS) begin
            clr_refused = reg_wdata[`FSP_ST_REFUSED_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_q         = q;
      next_q.prog_en = 1'b0;
      next_q.rdata   = 32'h00000000;

      // Load sequence: one read per word, data returns the cycle after
      unique case (q.st)
         ST_RD_SEC:   next_q.st = ST_WAIT_SEC;
         ST_WAIT_SEC: next_q.st = ST_RD_LIM;
         ST_RD_LIM:   next_q.st = ST_WAIT_LIM;
         ST_WAIT_LIM: next_q.st = ST_READY;
         ST_READY:    next_q.st = ST_READY;
      endcase

      // Programming can only clear bits; unimplemented ones are forced high
      if (reg_wr && !set_refused) begin
         if (reg_addr == `FSP_REG_SEC) begin
            next_q.prog_en   = 1'b1;
            next_q.prog_addr = SEC_NVM_ADDR[NVM_AW-1:0];
            next_q.prog_data = (sec_word & reg_wdata[23:0]) | ~`FSP_SEC_IMPL_MASK;
         end else if (reg_addr == `FSP_REG_LIM) begin
            next_q.prog_en   = 1'b1;
            next_q.prog_addr = LIM_NVM_ADDR[NVM_AW-1:0];
            next_q.prog_data = (lim_word & reg_wdata[23:0]) | ~`FSP_LIM_IMPL_MASK;
         end
      end

      // A refusal in the same cycle as its clear stays visible
      next_q.refused = (q.refused && !clr_refused) || set_refused;

      // Register reads
      if (reg_rd) begin
         unique case (reg_addr)
            `FSP_REG_SEC:    next_q.rdata = {8'h00, sec_word};
            `FSP_REG_LIM:    next_q.rdata = {8'h00, lim_word};
            `FSP_REG_STATUS: begin
               next_q.rdata[`FSP_ST_VALID_BIT]   = ready;
               next_q.rdata[`FSP_ST_REFUSED_BIT] = q.refused;
               next_q.rdata[`FSP_ST_BOOTSEG_BIT] = boot_segment_present;
            end
            default:         next_q.rdata = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         q.st        <= ST_RD_SEC;
         q.rdata     <= 32'h00000000;
         q.prog_en   <= 1'b0;
         q.prog_addr <= '0;
         q.prog_data <= `FSP_UNPROG_WORD;
         q.refused   <= 1'b0;
      end else begin
         q <= next_q;
      end
   end

endmodule

// file: sim/fsp_protect_checker.sv
// Port assertions for the segment protection decoder
`timescale 1ns/1ns
`include "fsp_defs.svh"
module fsp_protect_checker #(
   parameter int          NVM_AW       = 24,
   parameter logic [23:0] SEC_NVM_ADDR = `FSP_SEC_NVM_ADDR,
   parameter logic [23:0] LIM_NVM_ADDR = `FSP_LIM_NVM_ADDR
) (
   // Clock and reset
   input wire logic                sys_clk,
   input wire logic                resetn,
   // Register port
   input wire logic [7:0]          reg_addr,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire logic [31:0]         reg_rdata,
   // Memory side
   input wire logic                nvm_rd_en,
   input wire logic [NVM_AW-1:0]   nvm_rd_addr,
   input wire logic                nvm_prog_en,
   // Flash check
   input wire logic                flash_wr_req,
   input wire logic                flash_wr_cfg_seg,
   input wire logic [12:0]         flash_wr_page,
   input wire logic                flash_wr_grant,
   input wire logic                flash_wr_deny,
   input wire fsp_pkg::fsp_seg_t   flash_wr_segment,
   // Decoded protection
   input wire logic                config_valid,
   input wire logic                alt_vector_table_disable,
   input wire fsp_pkg::fsp_level_t config_segment_security_level,
   input wire fsp_pkg::fsp_level_t general_segment_security_level,
   input wire fsp_pkg::fsp_level_t boot_segment_security_level,
   input wire logic                config_segment_wr_locked,
   input wire logic                general_segment_wr_locked,
   input wire logic                boot_segment_wr_locked,
   input wire logic                boot_segment_present,
   input wire logic [12:0]         boot_segment_first_general_page
);
   import fsp_pkg::*;
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic rd_sec;
   logic rd_lim;
   // Reads only after load, so the read word and the controls agree
   assign rd_sec = reg_rd && reg_addr == `FSP_REG_SEC && config_valid;
   assign rd_lim = reg_rd && reg_addr == `FSP_REG_LIM && config_valid;
   function automatic logic [1:0] lv3(input logic [2:0] f);
      return f == 3'h7 ? 2'h0 : f == 3'h6 ? 2'h1 : f[2] ? 2'h2 : 2'h3;
   endfunction
   function automatic logic [1:0] lv2(input logic [1:0] f);
      return f == 2'h3 ? 2'h0 : f == 2'h2 ? 2'h1 : 2'h3;
   endfunction
   a_load_order: assert property ($rose(resetn) |-> nvm_rd_en && nvm_rd_addr == SEC_NVM_ADDR
      ##2 nvm_rd_en && nvm_rd_addr == LIM_NVM_ADDR ##2 config_valid)
      else $error("config words not loaded in order");
   a_static_hold: assert property (config_valid |=> config_valid && $stable({
      alt_vector_table_disable, config_segment_security_level, general_segment_security_level,
      boot_segment_security_level, config_segment_wr_locked, general_segment_wr_locked,
      boot_segment_wr_locked, boot_segment_present, boot_segment_first_general_page}))
      else $error("decoded controls changed without reset");
   a_vec_disable: assert property (rd_sec |=> reg_rdata[15] == alt_vector_table_disable)
      else $error("vector table disable wrong");
   a_cfg_level: assert property (rd_sec |=> config_segment_security_level == lv3(reg_rdata[11:9]))
      else $error("config level wrong");
   a_seg_levels: assert property (rd_sec |=> general_segment_security_level == lv2(reg_rdata[7:6])
      && boot_segment_security_level == lv2(reg_rdata[2:1]))
      else $error("general or boot level wrong");
   a_lock_bits: assert property (rd_sec |=> {config_segment_wr_locked, general_segment_wr_locked,
      boot_segment_wr_locked} == ~{reg_rdata[8], reg_rdata[5], reg_rdata[0]})
      else $error("write lock wrong");
   a_boot_enable: assert property (rd_sec |=> boot_segment_present == !reg_rdata[3])
      else $error("boot presence wrong");
   a_limit_invert: assert property (rd_lim |=> boot_segment_first_general_page == ~reg_rdata[12:0])
      else $error("boot limit not inverted");
   a_upper_ones: assert property (rd_sec || rd_lim |=> reg_rdata[31:16] == 16'h00ff)
      else $error("upper word bits wrong");
   a_wr_grant: assert property (flash_wr_req |-> flash_wr_deny == !flash_wr_grant
      && flash_wr_grant == (config_valid && !(flash_wr_segment == SEG_CONFIG ?
      config_segment_wr_locked : flash_wr_segment == SEG_BOOT ? boot_segment_wr_locked :
      general_segment_wr_locked)))
      else $error("flash write verdict wrong");
   a_boot_class: assert property (flash_wr_req && config_valid |-> flash_wr_segment ==
      (flash_wr_cfg_seg ? SEG_CONFIG : (boot_segment_present &&
      flash_wr_page < boot_segment_first_general_page) ? SEG_BOOT : SEG_GENERAL))
      else $error("segment class wrong");
   a_prog_guard: assert property (nvm_prog_en |-> $past(reg_wr) && $past(config_valid)
      && !$past(config_segment_wr_locked))
      else $error("program pulse without permitted write");
   c_loaded: cover property ($rose(config_valid));
   c_program: cover property (nvm_prog_en);
   c_boot_deny: cover property (flash_wr_req && flash_wr_segment == SEG_BOOT && flash_wr_deny);
endmodule

bind fsp_protect_top fsp_protect_checker #(.NVM_AW(NVM_AW), .SEC_NVM_ADDR(SEC_NVM_ADDR),
   .LIM_NVM_ADDR(LIM_NVM_ADDR)) u_chk (.sys_clk, .resetn, .reg_addr, .reg_wr, .reg_rd,
   .reg_rdata, .nvm_rd_en, .nvm_rd_addr, .nvm_prog_en, .flash_wr_req, .flash_wr_cfg_seg,
   .flash_wr_page, .flash_wr_grant, .flash_wr_deny, .flash_wr_segment, .config_valid,
   .alt_vector_table_disable, .config_segment_security_level, .general_segment_security_level,
   .boot_segment_security_level, .config_segment_wr_locked, .general_segment_wr_locked,
   .boot_segment_wr_locked, .boot_segment_present, .boot_segment_first_general_page);

// file: sim/fsp_nvm_model.sv
// Behavioural configuration memory on the far side of the decoder
`timescale 1ns/1ns
`include "fsp_defs.svh"
module fsp_nvm_model #(
   parameter logic [23:0] SEC_ADDR = `FSP_SEC_NVM_ADDR
) (
   // Clock
   input  wire logic        sys_clk,
   // Read port
   input  wire logic        rd_en,
   input  wire logic [23:0] rd_addr,
   output logic      [23:0] rd_data,
   // Program port
   input  wire logic        prog_en,
   input  wire logic [23:0] prog_addr,
   input  wire logic [23:0] prog_data
);
   // ------------------------------------------------------------
   // Storage, erased state is all ones
   // ------------------------------------------------------------
   logic [23:0] sec_word = 24'hffffff;
   logic [23:0] lim_word = 24'hffffff;
   initial rd_data = 24'h000000;
   always @(posedge sys_clk) begin
      // Off-cycle data flips so a late sample cannot look right
      if (rd_en) begin
         rd_data <= (rd_addr == SEC_ADDR) ? sec_word : lim_word;
      end else begin
         rd_data <= ~rd_data;
      end
      // Programming only clears bits, a cleared bit never returns
      if (prog_en && prog_addr == SEC_ADDR) begin
         sec_word <= sec_word & prog_data;
      end else if (prog_en) begin
         lim_word <= lim_word & prog_data;
      end
   end
endmodule

// file: sim/testbench.sv
// Self-checking bench for the segment protection decoder
`timescale 1ns/1ns
`include "fsp_defs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
   import fsp_pkg::*;
   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        flash_wr_req = 1'b0;
   logic        flash_wr_cfg_seg = 1'b0;
   logic [12:0] flash_wr_page = 13'h0;
   logic [31:0] reg_rdata, rdata;
   logic [23:0] nvm_rd_addr, nvm_rd_data, nvm_prog_addr, nvm_prog_data;
   logic        nvm_rd_en, nvm_prog_en, flash_wr_grant, flash_wr_deny, config_valid;
   logic        alt_vector_table_disable, boot_segment_present;
   logic        config_segment_wr_locked, general_segment_wr_locked, boot_segment_wr_locked;
   fsp_seg_t    flash_wr_segment;
   fsp_level_t  config_segment_security_level, general_segment_security_level;
   fsp_level_t  boot_segment_security_level;
   logic [12:0] boot_segment_first_general_page;
   int          n_mismatch = 0, check_count = 0, seed = 98, sec, lim, d, fb;

   fsp_protect_top u_dut (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .nvm_rd_en, .nvm_rd_addr, .nvm_rd_data, .nvm_prog_en, .nvm_prog_addr,
      .nvm_prog_data, .flash_wr_req, .flash_wr_cfg_seg, .flash_wr_page, .flash_wr_grant,
      .flash_wr_deny, .flash_wr_segment, .config_valid, .alt_vector_table_disable,
      .config_segment_security_level, .general_segment_security_level,
      .boot_segment_security_level, .config_segment_wr_locked, .general_segment_wr_locked,
      .boot_segment_wr_locked, .boot_segment_present, .boot_segment_first_general_page);
   fsp_nvm_model u_mem (.sys_clk, .rd_en(nvm_rd_en), .rd_addr(nvm_rd_addr),
      .rd_data(nvm_rd_data), .prog_en(nvm_prog_en), .prog_addr(nvm_prog_addr),
      .prog_data(nvm_prog_data));

   // ------------------------------------------------------------
   // Model and bus tasks
   // ------------------------------------------------------------
   always #10 sys_clk = ~sys_clk;
   function automatic logic [1:0] lv3(int f);
      return f == 7 ? 2'h0 : f == 6 ? 2'h1 : f >= 4 ? 2'h2 : 2'h3;
   endfunction
   function automatic logic [1:0] lv2(int f);
      return f == 3 ? 2'h0 : f == 2 ? 2'h1 : 2'h3;
   endfunction
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input int v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rdata = reg_rdata;
   endtask
   task automatic fq(input logic c, input int p);
      int seg, lck;
      @(posedge sys_clk);
      flash_wr_req <= 1'b1;
      flash_wr_cfg_seg <= c;
      flash_wr_page <= p[12:0];
      #1;
      seg = c ? 2 : (!sec[3] && (p & 'h1fff) < ((~lim) & 'h1fff)) ? 0 : 1;
      lck = c ? !sec[8] : seg == 0 ? !sec[0] : !sec[5];
      `CHK(flash_wr_segment, 2'(seg))
      `CHK({flash_wr_grant, flash_wr_deny}, lck ? 2'b01 : 2'b10)
   endtask
   task automatic check_all();
      `CHK(alt_vector_table_disable, sec[15])
      `CHK(config_segment_security_level, lv3((sec >> 9) & 7))
      `CHK(config_segment_wr_locked, !sec[8])
      `CHK(general_segment_security_level, lv2((sec >> 6) & 3))
      `CHK(general_segment_wr_locked, !sec[5])
      `CHK(boot_segment_present, !sec[3])
      `CHK(boot_segment_security_level, lv2((sec >> 1) & 3))
      `CHK(boot_segment_wr_locked, !sec[0])
      `CHK(boot_segment_first_general_page, 13'(~lim))
      rd(`FSP_REG_SEC);
      `CHK(rdata, (sec | 32'h00ff7010) & 32'h00ffffff)
      rd(`FSP_REG_LIM);
      `CHK(rdata, (lim | 32'h00ffe000) & 32'h00ffffff)
   endtask
   task automatic rst_load();
      resetn <= 1'b0;
      flash_wr_req <= 1'b1;
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      #1;
      `CHK(flash_wr_deny, 1'b1)
      flash_wr_req <= 1'b0;
      for (int k = 0; k < 20 && config_valid !== 1'b1; k++) @(posedge sys_clk);
      `CHK(config_valid, 1'b1)
      check_all();
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      for (int i = 0; i < 9; i++) begin
         sec = 'hffffff;
         lim = 'hffffff;
         if (i > 0) begin
            // All level codes, both boot settings; reserved bits are random too
            sec = $random(seed) & 'hffffff;
            sec[11:9] = i[2:0];
            sec[7:6] = i[1:0];
            sec[2:1] = i[1:0];
            sec[3] = i[0];
            lim = $random(seed) & 'hffffff;
         end
         u_mem.sec_word = 24'(sec);
         u_mem.lim_word = 24'(lim);
         rst_load();
         fb = (~lim) & 'h1fff;
         fq(1'b0, fb - 1);
         fq(1'b0, fb);
         fq(1'b1, $random(seed));
      end
      sec = 'hffffff;
      lim = 'hffffff;
      {u_mem.sec_word, u_mem.lim_word} = '1;
      rst_load();
      d = $random(seed) & ~'h100;
      wr(`FSP_REG_SEC, d);
      `CHK({nvm_prog_en, nvm_prog_addr}, {1'b1, `FSP_SEC_NVM_ADDR})
      `CHK(nvm_prog_data, 24'((sec & d) | 'hff7010))
      check_all();
      sec = (sec & d) | 'hff7010;
      rst_load();
      wr(`FSP_REG_LIM, 0);
      `CHK(nvm_prog_en, 1'b0)
      rd(`FSP_REG_STATUS);
      `CHK(rdata, sec[3] ? 32'h3 : 32'h7)
      wr(`FSP_REG_STATUS, 2);
      rd(`FSP_REG_STATUS);
      `CHK(rdata, sec[3] ? 32'h1 : 32'h5)
      rd(8'h0c);
      `CHK(rdata, 32'h0)
      report_and_stop();
   end
endmodule
